// ==== rtl/xpd_pkg.sv ====
// xpd_pkg: shared constants and types for the extension-bus decoder.
// assumes one 200 MHz core clock; all routing ranges sit in segment 0.
package xpd_pkg;
   localparam logic [15:0] XPD_SEL_OFFSET = 16'hF024;
   localparam logic [15:0] XPD_SEL_RESET = 16'h0005;
   localparam int XPD_FIRST_CAN_BIT = 0;
   localparam int XPD_SECOND_CAN_BIT = 1;
   localparam int XPD_SMALL_RAM_BIT = 2;
   localparam int XPD_LARGE_RAM_BIT = 3;
   localparam int XPD_RTC_BIT = 4;
   localparam logic [15:0] XPD_SEL_MASK = 16'h001F;
   localparam logic [23:0] XPD_LRAM_LO = 24'h00_C000;
   localparam logic [23:0] XPD_LRAM_HI = 24'h00_DFFF;
   localparam logic [23:0] XPD_SRAM_LO = 24'h00_E000;
   localparam logic [23:0] XPD_SRAM_HI = 24'h00_E7FF;
   localparam logic [23:0] XPD_RTC_LO = 24'h00_EC00;
   localparam logic [23:0] XPD_RTC_HI = 24'h00_ECFF;
   localparam logic [23:0] XPD_CAN2_LO = 24'h00_EE00;
   localparam logic [23:0] XPD_CAN2_HI = 24'h00_EEFF;
   localparam logic [23:0] XPD_CAN1_LO = 24'h00_EF00;
   localparam logic [23:0] XPD_CAN1_HI = 24'h00_EFFF;
   localparam int XPD_CLK_PERIOD_PS = 5000;
   localparam int XPD_RAM_ACCESS_NS = 50;
   localparam int XPD_CAN_ACCESS_NS = 100;
   localparam int XPD_RTC_ACCESS_NS = 100;
   localparam logic [4:0] XPD_RAM_CYC =
      5'((XPD_RAM_ACCESS_NS * 1000 + XPD_CLK_PERIOD_PS - 1) / XPD_CLK_PERIOD_PS);
   localparam logic [4:0] XPD_CAN_CYC =
      5'((XPD_CAN_ACCESS_NS * 1000 + XPD_CLK_PERIOD_PS - 1) / XPD_CLK_PERIOD_PS);
   localparam logic [4:0] XPD_RTC_CYC =
      5'((XPD_RTC_ACCESS_NS * 1000 + XPD_CLK_PERIOD_PS - 1) / XPD_CLK_PERIOD_PS);
   localparam logic [4:0] XPD_CNT_RESET = 5'h00;
   localparam logic [15:0] XPD_DATA_RESET = 16'h0000;
   localparam logic [2:0] XPD_SYNC_RESET = 3'b000;

   typedef enum logic [2:0] {
      XPD_RT_EXT = 3'b000,
      XPD_RT_SRAM = 3'b001,
      XPD_RT_LRAM = 3'b010,
      XPD_RT_CAN1 = 3'b011,
      XPD_RT_CAN2 = 3'b100,
      XPD_RT_RTC = 3'b101,
      XPD_RT_NONE = 3'b110
   } xpd_route_t;

   typedef enum logic [1:0] {
      XPD_ST_IDLE = 2'b00,
      XPD_ST_ONCHIP = 2'b01,
      XPD_ST_EXTERN = 2'b10
   } xpd_state_t;

   // one cpu access as seen by every target
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic [1:0] byte_en;
      logic write;
   } xpd_access_t;

   // strobes towards the on-chip units, one-hot
   typedef struct packed {
      logic sram;
      logic lram;
      logic can1;
      logic can2;
      logic rtc;
   } xpd_unit_sel_t;
endpackage

// ==== rtl/xpd_decoder.sv ====
// xpd_decoder: routes cpu accesses in upper segment 0 to on-chip units or the
// external bus controller, holds the peripheral-select register.
// assumes cpu, units and external controller share clk_in; emulation pin is async.
//
// Summary of operation
// - small ram at E000-E7FF when global and bit2
// - otherwise that range goes to external bus
// - large ram at C000-DFFF when global and bit3
// - otherwise that range goes to external bus
// - EF00-EFFF to first controller when bit0
// - EE00-EEFF to second controller when bit1
// - controller access: 16-bit, bytes, 100ns
// - ram access: 16-bit, bytes and words, 50ns
// - controller ranges external only if both disabled
// - disabled controller releases its port pins
// - rtc range external only if controllers disabled
// - select register resets to 05h
// - select register frozen once global enable set
// - disabled unit occupies no space, pins, interrupts
// - emulation mode treats all enables as set
// - oscillator stop in power-down follows rtc enable
// - controllers in use limit segment lines to four
module xpd_decoder
   import xpd_pkg::*;
(
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // sync reset, low
   input wire logic global_extension_enable_in, // from system_config
   input wire logic emulation_mode_in, // async pin
   input wire logic power_down_in, // core entering power-down
   input wire logic rtc_oscillator_off_in, // from rtc_control
   input wire logic reg_wr_in, // register write strobe
   input wire logic reg_rd_in, // register read strobe
   input wire logic [15:0] reg_addr_in, // register address
   input wire logic [15:0] reg_wdata_in, // register write data
   output logic [15:0] reg_rdata_out, // register read data
   input wire logic cpu_req_in, // access request
   input wire xpd_access_t cpu_acc_in, // access payload
   output logic cpu_busy_out, // not ready for a request
   output logic cpu_ack_out, // access done pulse
   output logic [15:0] cpu_rdata_out, // read data
   output xpd_access_t xbus_acc_out, // payload to units and ext
   output xpd_unit_sel_t xbus_sel_out, // unit selects
   input wire logic [15:0] xbus_rdata_in, // unit read data
   output logic ext_req_out, // external cycle pulse
   input wire logic ext_done_in, // external cycle done pulse
   input wire logic [15:0] ext_rdata_in, // external read data
   output logic emu_routing_out, // companion chip governs routing
   output logic p4_4_7_gpio_out, // pins free for gpio
   output logic p4_5_6_gpio_out, // pins free for gpio
   output logic [1:0] can_irq_en_out, // controller interrupt hookup
   output logic seg_lines_four_out, // only 4 segment lines
   output logic osc_stop_out // stop oscillator in power-down
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [15:0] sel_r;
   logic lock_r;
   logic [2:0] emu_sync_r;
   logic emu_r;
   logic [15:0] eff;
   logic glob;
   xpd_route_t route;
   xpd_state_t state_r;
   xpd_route_t route_r;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // emulation pin: three stages, change accepted once last two agree
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         emu_sync_r <= XPD_SYNC_RESET;
         emu_r <= 1'b0;
      end else begin
         emu_sync_r <= {emu_sync_r[1:0], emulation_mode_in};
         if (emu_sync_r[2] == emu_sync_r[1]) begin
            emu_r <= emu_sync_r[2];
         end
      end
   end

   // lock is sticky: clearing the global bit later must not reopen the register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lock_r <= 1'b0;
      end else if (global_extension_enable_in) begin
         lock_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sel_r <= XPD_SEL_RESET;
      end else if (reg_wr_in && reg_addr_in == XPD_SEL_OFFSET && !lock_r
                   && !global_extension_enable_in) begin
         sel_r <= reg_wdata_in & XPD_SEL_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= XPD_DATA_RESET;
      end else if (reg_rd_in) begin
         reg_rdata_out <= (reg_addr_in == XPD_SEL_OFFSET) ? sel_r : XPD_DATA_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign eff = emu_r ? XPD_SEL_MASK : sel_r;
   assign glob = global_extension_enable_in;

   always_comb begin
      route = XPD_RT_EXT;
      if (glob) begin
         if (in_range(cpu_acc_in.addr, XPD_SRAM_LO, XPD_SRAM_HI)) begin
            route = eff[XPD_SMALL_RAM_BIT] ? XPD_RT_SRAM : XPD_RT_EXT;
         end else if (in_range(cpu_acc_in.addr, XPD_LRAM_LO, XPD_LRAM_HI)) begin
            route = eff[XPD_LARGE_RAM_BIT] ? XPD_RT_LRAM : XPD_RT_EXT;
         end else if (in_range(cpu_acc_in.addr, XPD_CAN1_LO, XPD_CAN1_HI)) begin
            if (eff[XPD_FIRST_CAN_BIT]) begin
               route = XPD_RT_CAN1;
            end else if (!eff[XPD_SECOND_CAN_BIT]) begin
               route = XPD_RT_EXT;
            end else begin
               route = XPD_RT_NONE;
            end
         end else if (in_range(cpu_acc_in.addr, XPD_CAN2_LO, XPD_CAN2_HI)) begin
            if (eff[XPD_SECOND_CAN_BIT]) begin
               route = XPD_RT_CAN2;
            end else if (!eff[XPD_FIRST_CAN_BIT]) begin
               route = XPD_RT_EXT;
            end else begin
               route = XPD_RT_NONE;
            end
         end else if (in_range(cpu_acc_in.addr, XPD_RTC_LO, XPD_RTC_HI)) begin
            if (eff[XPD_RTC_BIT]) begin
               route = XPD_RT_RTC;
            end else if (!eff[XPD_FIRST_CAN_BIT] && !eff[XPD_SECOND_CAN_BIT]) begin
               route = XPD_RT_EXT;
            end else begin
               route = XPD_RT_NONE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // unit wait time; ram and controllers are both demuxed 16-bit with byte lanes
   function automatic logic [4:0] unit_cycles(input xpd_route_t r);
      case (r)
         XPD_RT_SRAM, XPD_RT_LRAM: unit_cycles = XPD_RAM_CYC;
         XPD_RT_CAN1, XPD_RT_CAN2: unit_cycles = XPD_CAN_CYC;
         XPD_RT_RTC: unit_cycles = XPD_RTC_CYC;
         default: unit_cycles = 5'h01;
      endcase
   endfunction

   assign cpu_busy_out = (state_r != XPD_ST_IDLE);
   assign cnt_nxt = cnt_r - 5'h01;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_r <= XPD_ST_IDLE;
         route_r <= XPD_RT_EXT;
         cnt_r <= XPD_CNT_RESET;
      end else begin
         case (state_r)
            XPD_ST_IDLE: begin
               if (cpu_req_in) begin
                  route_r <= route;
                  cnt_r <= unit_cycles(route);
                  state_r <= (route == XPD_RT_EXT) ? XPD_ST_EXTERN : XPD_ST_ONCHIP;
               end
            end
            XPD_ST_ONCHIP: begin
               cnt_r <= cnt_nxt;
               if (cnt_r == 5'h01) begin
                  state_r <= XPD_ST_IDLE;
               end
            end
            XPD_ST_EXTERN: begin
               if (ext_done_in) begin
                  state_r <= XPD_ST_IDLE;
               end
            end
            default: state_r <= XPD_ST_IDLE;
         endcase
      end
   end

   // payload and selects held for the whole unit access
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         xbus_acc_out <= '0;
         xbus_sel_out <= '0;
         ext_req_out <= 1'b0;
      end else begin
         ext_req_out <= 1'b0;
         if (state_r == XPD_ST_IDLE && cpu_req_in) begin
            xbus_acc_out <= cpu_acc_in;
            xbus_sel_out.sram <= (route == XPD_RT_SRAM);
            xbus_sel_out.lram <= (route == XPD_RT_LRAM);
            xbus_sel_out.can1 <= (route == XPD_RT_CAN1);
            xbus_sel_out.can2 <= (route == XPD_RT_CAN2);
            xbus_sel_out.rtc <= (route == XPD_RT_RTC);
            ext_req_out <= (route == XPD_RT_EXT);
         end else if (state_r == XPD_ST_ONCHIP && cnt_r == 5'h01) begin
            xbus_sel_out <= '0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cpu_ack_out <= 1'b0;
         cpu_rdata_out <= XPD_DATA_RESET;
      end else begin
         cpu_ack_out <= 1'b0;
         if (state_r == XPD_ST_ONCHIP && cnt_r == 5'h01) begin
            cpu_ack_out <= 1'b1;
            // an invisible unit reads as zero
            cpu_rdata_out <= (route_r == XPD_RT_NONE) ? XPD_DATA_RESET : xbus_rdata_in;
         end else if (state_r == XPD_ST_EXTERN && ext_done_in) begin
            cpu_ack_out <= 1'b1;
            cpu_rdata_out <= ext_rdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         emu_routing_out <= 1'b0;
         p4_4_7_gpio_out <= 1'b1;
         p4_5_6_gpio_out <= 1'b1;
         can_irq_en_out <= 2'b00;
         seg_lines_four_out <= 1'b0;
         osc_stop_out <= 1'b0;
      end else begin
         emu_routing_out <= emu_r;
         p4_4_7_gpio_out <= !(glob && eff[XPD_SECOND_CAN_BIT]);
         p4_5_6_gpio_out <= !(glob && eff[XPD_FIRST_CAN_BIT]);
         can_irq_en_out <= glob ? eff[1:0] : 2'b00;
         seg_lines_four_out <= glob && (eff[0] || eff[1]);
         osc_stop_out <= power_down_in &&
                         (!(glob && eff[XPD_RTC_BIT]) || rtc_oscillator_off_in);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_take_ram;
      state_r == XPD_ST_IDLE && cpu_req_in && route == XPD_RT_SRAM;
   endsequence
   sequence s_take_can;
      state_r == XPD_ST_IDLE && cpu_req_in && route == XPD_RT_CAN1;
   endsequence

   // ack is registered on the tenth count edge, so it is seen one edge later
   AST_RAM_TIME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_take_ram |-> ##1 (!cpu_ack_out [*5] ##1 !cpu_ack_out [*5]) ##1 cpu_ack_out)
      else $error("ram access not 10 cycles");
   AST_CAN_TIME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_take_can |-> ##21 cpu_ack_out)
      else $error("controller access not 20 cycles");
   AST_SRAM_MAP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_take_ram |-> glob && eff[XPD_SMALL_RAM_BIT] ##1 xbus_sel_out.sram)
      else $error("small ram selected while disabled");
   AST_SRAM_EXT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r == XPD_ST_IDLE && cpu_req_in && !eff[XPD_SMALL_RAM_BIT]
       && in_range(cpu_acc_in.addr, XPD_SRAM_LO, XPD_SRAM_HI)) |=> ext_req_out)
      else $error("disabled small ram not routed out");
   AST_LRAM_EXT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r == XPD_ST_IDLE && cpu_req_in && !glob
       && in_range(cpu_acc_in.addr, XPD_LRAM_LO, XPD_LRAM_HI)) |=> ext_req_out)
      else $error("large ram range not external without global enable");
   AST_RESET_VAL: assert property (@(posedge clk_in)
      !rst_n_in |=> sel_r == XPD_SEL_RESET)
      else $error("select register reset value wrong");
   AST_FROZEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      lock_r |=> $stable(sel_r))
      else $error("select register changed after lock");
   AST_PINS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !eff[XPD_SECOND_CAN_BIT] |=> p4_4_7_gpio_out)
      else $error("pins not released");
   AST_CAN_BOTH_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r == XPD_ST_IDLE && cpu_req_in && glob && !eff[0] && !eff[1]
       && in_range(cpu_acc_in.addr, XPD_CAN2_LO, XPD_CAN1_HI)) |=> ext_req_out)
      else $error("controller range not external");
   AST_EMU_ALL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      emu_r && glob |=> !p4_4_7_gpio_out && !p4_5_6_gpio_out && can_irq_en_out == 2'b11)
      else $error("emulation enables not all set");
endmodule // xpd_decoder

// ==== bench/xpd_unit_model.sv ====
// xpd_unit_model: on-chip units plus external bus controller facing the decoder.
// assumes one shared clock; external cycles end after a short or a long wait.
module xpd_unit_model
   import xpd_pkg::*;
(
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // sync reset, low
   input wire logic slow_in, // stretch external cycles
   input wire xpd_access_t xbus_acc_in, // payload from decoder
   input wire xpd_unit_sel_t xbus_sel_in, // unit selects
   input wire logic ext_req_in, // external cycle pulse
   output logic [15:0] xbus_rdata_out, // unit read data
   output logic ext_done_out, // external done pulse
   output logic [15:0] ext_rdata_out // external read data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_r;
   logic busy_r;
   logic [15:0] last_r;
   logic [15:0] ext_addr_r;
   ////////////////////////////////////////////////////////////////////////
   // released bus shows the inverse of its last value, never a held copy
   always_comb begin
      if (xbus_sel_in != '0) begin
         xbus_rdata_out = xbus_acc_in.addr[15:0] ^ 16'h5A5A;
      end else begin
         xbus_rdata_out = ~last_r;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         last_r <= 16'h0000;
      end else if (xbus_sel_in != '0) begin
         last_r <= xbus_acc_in.addr[15:0] ^ 16'h5A5A;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      ext_done_out <= 1'b0;
      if (!rst_n_in) begin
         busy_r <= 1'b0;
         wait_r <= 4'h0;
         ext_addr_r <= 16'h0000;
      end else if (ext_req_in) begin
         busy_r <= 1'b1;
         wait_r <= slow_in ? 4'h7 : 4'h1;
         ext_addr_r <= xbus_acc_in.addr[15:0];
      end else if (busy_r) begin
         if (wait_r == 4'h0) begin
            busy_r <= 1'b0;
            ext_done_out <= 1'b1;
         end else begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
   assign ext_rdata_out = ext_done_out ? ext_addr_r ^ 16'hC3C3 : ~(ext_addr_r ^ 16'hC3C3);
endmodule // xpd_unit_model

// ==== bench/xpd_decoder_tb.sv ====
// xpd_decoder_tb: self-checking bench for the extension-bus decoder.
// assumes xpd_unit_model stands for the on-chip units and the external controller.
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("[ERR] %s expected %h seen %h", nm, e, g); \
      end \
   end
module xpd_decoder_tb
   import xpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in, rst_n_in, glob, emu, pd, rtc_off, reg_wr, reg_rd, cpu_req, slow;
   logic busy, ack, ext_req, ext_done, emu_rt, gp47, gp56, seg4, osc_stop;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, cpu_rdata, xrdata, ext_rdata;
   logic [1:0] irq_en;
   xpd_access_t cpu_acc, xacc;
   xpd_unit_sel_t xsel;
   int fail_count = 0;
   int checks_done = 0;
   ////////////////////////////////////////////////////////////////////////
   xpd_decoder dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .global_extension_enable_in(glob), .emulation_mode_in(emu), .power_down_in(pd),
      .rtc_oscillator_off_in(rtc_off), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
      .cpu_req_in(cpu_req), .cpu_acc_in(cpu_acc), .cpu_busy_out(busy), .cpu_ack_out(ack),
      .cpu_rdata_out(cpu_rdata), .xbus_acc_out(xacc), .xbus_sel_out(xsel),
      .xbus_rdata_in(xrdata), .ext_req_out(ext_req), .ext_done_in(ext_done),
      .ext_rdata_in(ext_rdata), .emu_routing_out(emu_rt), .p4_4_7_gpio_out(gp47),
      .p4_5_6_gpio_out(gp56), .can_irq_en_out(irq_en), .seg_lines_four_out(seg4),
      .osc_stop_out(osc_stop));
   xpd_unit_model partner_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
      .xbus_acc_in(xacc), .xbus_sel_in(xsel), .ext_req_in(ext_req),
      .xbus_rdata_out(xrdata), .ext_done_out(ext_done), .ext_rdata_out(ext_rdata));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic reset_dut();
      @(negedge clk_in);
      rst_n_in = 1'b0;
      glob = 1'b0;
      emu = 1'b0;
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
   endtask
   task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_in);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_in);
      reg_wr = 1'b0;
   endtask
   task automatic reg_check(input logic [15:0] a, input logic [15:0] e);
      @(negedge clk_in);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_in);
      reg_rd = 1'b0;
      @(negedge clk_in);
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   // lat: 0 external, 1 invisible, else on-chip cycles from take to ack
   task automatic access(input logic [23:0] a, input logic [1:0] be, input logic [4:0] es,
                         input int lat);
      int n;
      logic [4:0] ss;
      logic ex;
      xpd_access_t sent;
      sent = '{addr: a, wdata: 16'h0000, byte_en: be, write: 1'b0};
      n = 0;
      ss = 5'h00;
      ex = 1'b0;
      @(negedge clk_in);
      cpu_req = 1'b1;
      cpu_acc = sent;
      @(negedge clk_in);
      cpu_req = 1'b0;
      ss |= xsel;
      ex |= ext_req;
      while (n < 60) begin
         @(negedge clk_in);
         n++;
         ss |= xsel;
         ex |= ext_req;
         if (n == 1 && lat > 1) `CHK("xbus_acc", sent, xacc)
         if (n == 1 && lat > 1) `CHK("busy", 1'b1, busy)
         if (ack === 1'b1) break;
      end
      if (n >= 60) begin
         fail_count++;
         finish_test();
      end
      if (lat != 0) `CHK("latency", lat, n)
      `CHK("sel", es, ss)
      `CHK("ext_req", (lat == 0), ex)
      `CHK("rdata", (lat == 0) ? a[15:0] ^ 16'hC3C3 : (lat == 1) ? 16'h0000 :
           a[15:0] ^ 16'h5A5A, cpu_rdata)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      reg_check(16'hF024, 16'h0005);
      reg_check(16'hF026, 16'h0000);
      reg_write(16'hF024, 16'hFFFF);
      reg_check(16'hF024, 16'h001F);
      reg_write(16'hF024, 16'h000A);
      reg_check(16'hF024, 16'h000A);
      access(24'h00_E000, 2'b11, 5'h00, 0);
      access(24'h00_C000, 2'b11, 5'h00, 0);
      $display("test regs done");
   endtask
   task automatic t_enabled();
      glob = 1'b1;
      repeat (2) @(negedge clk_in);
      access(24'h00_C000, 2'b01, 5'h08, 10);
      access(24'h00_DFFF, 2'b11, 5'h08, 10);
      access(24'h00_E000, 2'b11, 5'h00, 0);
      access(24'h00_EE00, 2'b10, 5'h02, 20);
      access(24'h00_EF00, 2'b11, 5'h00, 1);
      access(24'h00_EC00, 2'b11, 5'h00, 1);
      `CHK("gpio47", 1'b0, gp47)
      `CHK("gpio56", 1'b1, gp56)
      `CHK("irq_en", 2'b10, irq_en)
      `CHK("seg4", 1'b1, seg4)
      pd = 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK("osc_stop", 1'b1, osc_stop)
      reg_write(16'hF024, 16'h0000);
      reg_check(16'hF024, 16'h000A);
      glob = 1'b0;
      reg_write(16'hF024, 16'h0000);
      reg_check(16'hF024, 16'h000A);
      $display("test enabled done");
   endtask
   task automatic t_default();
      reset_dut();
      glob = 1'b1;
      repeat (2) @(negedge clk_in);
      access(24'h00_E000, 2'b10, 5'h10, 10);
      access(24'h00_E7FF, 2'b11, 5'h10, 10);
      access(24'h00_EFFF, 2'b01, 5'h04, 20);
      access(24'h00_C000, 2'b11, 5'h00, 0);
      access(24'h00_EE00, 2'b11, 5'h00, 1);
      `CHK("gpio47", 1'b1, gp47)
      `CHK("gpio56", 1'b0, gp56)
      emu = 1'b1;
      rtc_off = 1'b0;
      repeat (6) @(negedge clk_in);
      `CHK("emu_rt", 1'b1, emu_rt)
      access(24'h00_C000, 2'b11, 5'h08, 10);
      access(24'h00_EC00, 2'b11, 5'h01, 20);
      `CHK("osc_stop", 1'b0, osc_stop)
      rtc_off = 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK("osc_stop", 1'b1, osc_stop)
      reg_check(16'hF024, 16'h0005);
      $display("test default done");
   endtask
   task automatic t_both_off();
      reset_dut();
      slow = 1'b1;
      reg_write(16'hF024, 16'h0000);
      glob = 1'b1;
      repeat (2) @(negedge clk_in);
      access(24'h00_EE00, 2'b11, 5'h00, 0);
      access(24'h00_EFFF, 2'b11, 5'h00, 0);
      access(24'h00_EC00, 2'b11, 5'h00, 0);
      `CHK("seg4", 1'b0, seg4)
      $display("test both_off done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_in = 1'b0;
      glob = 1'b0;
      emu = 1'b0;
      pd = 1'b0;
      rtc_off = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      cpu_req = 1'b0;
      cpu_acc = '0;
      slow = 1'b0;
      reset_dut();
      t_regs();
      t_enabled();
      t_default();
      t_both_off();
      finish_test();
   end
endmodule // xpd_decoder_tb
